// File: verilog/slc_device.sv
/*
  Device end of the serial link control block: register file reached over
  the link register port, link enable gating, LMFC counter, effective K and
  the combined sync request.
  Assumes CORE_CLK at 125 MHz, RST_N synchronous active low, and a
  controller that holds reg_req until it sees reg_ack.
*/
// Implementation choice: the APB interface to the registers.
// Notes on behaviour
// - enable bit 0 switches link, resets to 1
// - software clears enable before other config writes
// - enable low holds link block in reset
// - enable low powers serializers down, gates clocks
// - enable low holds multiframe counter, ignores SYSREF
// - software sets calibration before link enable
// - software clears enable before clearing calibration
// - 8-bit link mode, resets to two
// - mode written only with enable, calibration off
// - modes above mode lock are refused
// - K-1 field, reset 31 gives K 32
// - software writes only legal K values
// - 64b/66b modes derive K as 256*E/F
// - K-1 written only while link disabled
// - soft sync bit low requests sync
// - soft request works whatever source is selected
// - stuck pin escapes only via no-pin source
// - source select: pin, timestamp pin, none
`timescale 1ns/100ps
`include "slc_map.svh"
module slc_device
  import slc_pkg::*;
(
  input  wire logic         CORE_CLK,
  input  wire logic         RST_N,
  slc_link_if.dev           LINK,
  input  wire logic         SYSREF,
  output logic              LINK_RESET_N,
  output logic              SERDES_PWRDN,
  output logic              LINK_CLK_EN,
  output logic              LMFC_PULSE,
  output logic              SYNC_REQ_N,
  output slc_byte_t         LINK_MODE,
  output slc_kcount_t       K_EFFECTIVE,
  output logic              SCRAMBLE_EN,
  output logic              SAMPLE_SIGNED
);
  slc_byte_t   cal_enable_reg;
  slc_byte_t   mode_lock_reg;
  slc_byte_t   link_enable_reg;
  slc_byte_t   link_mode_reg;
  slc_byte_t   km1_reg;
  slc_byte_t   soft_sync_reg;
  slc_byte_t   link_control_reg;
  logic        ack_reg;
  slc_byte_t   rdata_reg;
  logic        wr_take;
  logic        rd_take;
  logic        link_on;
  logic [2:0]  sysref_reg;
  logic        sysref_rise;
  slc_kcount_t lmfc_cnt_reg;
  slc_kcount_t k_eff;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // 64b/66b: K = 256*E/F; E is fixed at its default, F taken from mode[1:0]
  function automatic slc_kcount_t k_from_mode(input slc_byte_t mode);
    logic [9:0] k_full;
    k_full = (`SLC_K_6466_FACTOR * `SLC_K_E_DEFAULT) >> mode[1:0];
    return k_full[8:0];
  endfunction

  function automatic logic is_6466(input slc_byte_t mode);
    return mode >= `SLC_MODE_6466_FIRST;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register port handshake: one ack per request, then a free cycle

  assign wr_take = LINK.reg_req & ~ack_reg & LINK.reg_wr;
  assign rd_take = LINK.reg_req & ~ack_reg & ~LINK.reg_wr;
  assign link_on = link_enable_reg[`SLC_BIT_ENABLE];

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= LINK.reg_req & ~ack_reg;
    end
  end

  // read data sampled at the same edge that raises ack
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rdata_reg <= 8'h00;
    end else if (rd_take) begin
      case (LINK.reg_addr)
        `SLC_OFS_CAL_ENABLE:   rdata_reg <= cal_enable_reg;
        `SLC_OFS_MODE_LOCK:    rdata_reg <= mode_lock_reg;
        `SLC_OFS_LINK_ENABLE:  rdata_reg <= link_enable_reg;
        `SLC_OFS_LINK_MODE:    rdata_reg <= link_mode_reg;
        `SLC_OFS_KM1:          rdata_reg <= km1_reg;
        `SLC_OFS_SOFT_SYNC:    rdata_reg <= soft_sync_reg;
        `SLC_OFS_LINK_CONTROL: rdata_reg <= link_control_reg;
        default:               rdata_reg <= 8'h00; // unmapped reads zero
      endcase
    end
  end

  assign LINK.reg_ack   = ack_reg;
  assign LINK.reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register writes; reserved bits are plain read/write storage

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      link_enable_reg <= `SLC_RST_LINK_ENABLE;
    end else if (wr_take && LINK.reg_addr == `SLC_OFS_LINK_ENABLE) begin
      link_enable_reg <= LINK.reg_wdata;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cal_enable_reg <= `SLC_RST_CAL_ENABLE;
      mode_lock_reg  <= `SLC_RST_MODE_LOCK;
    end else if (wr_take) begin
      if (LINK.reg_addr == `SLC_OFS_CAL_ENABLE) begin
        cal_enable_reg <= LINK.reg_wdata;
      end
      if (LINK.reg_addr == `SLC_OFS_MODE_LOCK) begin
        mode_lock_reg <= LINK.reg_wdata;
      end
    end
  end

  // a mode beyond the lock is dropped and the old mode stays
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      link_mode_reg <= `SLC_RST_LINK_MODE;
    end else if (wr_take && LINK.reg_addr == `SLC_OFS_LINK_MODE
                 && LINK.reg_wdata <= mode_lock_reg) begin
      link_mode_reg <= LINK.reg_wdata;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      km1_reg <= `SLC_RST_KM1;
    end else if (wr_take && LINK.reg_addr == `SLC_OFS_KM1) begin
      km1_reg <= LINK.reg_wdata;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      soft_sync_reg <= `SLC_RST_SOFT_SYNC;
    end else if (wr_take && LINK.reg_addr == `SLC_OFS_SOFT_SYNC) begin
      soft_sync_reg <= LINK.reg_wdata;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      link_control_reg <= `SLC_RST_LINK_CONTROL;
    end else if (wr_take && LINK.reg_addr == `SLC_OFS_LINK_CONTROL) begin
      link_control_reg <= LINK.reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link gating: all follow the enable bit one cycle later

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      LINK_RESET_N <= 1'b0;
      SERDES_PWRDN <= 1'b1;
      LINK_CLK_EN  <= 1'b0;
    end else begin
      LINK_RESET_N <= link_on;
      SERDES_PWRDN <= ~link_on;
      LINK_CLK_EN  <= link_on;
    end
  end

  // configuration seen by the link layer
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      LINK_MODE     <= `SLC_RST_LINK_MODE;
      K_EFFECTIVE   <= 9'h000;
      SCRAMBLE_EN   <= 1'b0;
      SAMPLE_SIGNED <= 1'b0;
    end else begin
      LINK_MODE     <= link_mode_reg;
      K_EFFECTIVE   <= k_eff;
      SCRAMBLE_EN   <= link_control_reg[0] | is_6466(link_mode_reg);
      SAMPLE_SIGNED <= link_control_reg[1];
    end
  end

  // K-1 field ignored in 64b/66b modes
  always_comb begin
    if (is_6466(link_mode_reg)) begin
      k_eff = k_from_mode(link_mode_reg);
    end else begin
      k_eff = {1'b0, km1_reg} + 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiframe counter, one frame per core clock

  // SYSREF is asynchronous; only the second and third stages are compared
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sysref_reg <= 3'h0;
    end else begin
      sysref_reg <= {sysref_reg[1:0], SYSREF};
    end
  end

  assign sysref_rise = sysref_reg[1] & ~sysref_reg[2];

  // held at zero while disabled, so a SYSREF edge has nothing to align
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      lmfc_cnt_reg <= 9'h000;
    end else if (!link_on) begin
      lmfc_cnt_reg <= 9'h000;
    end else if (sysref_rise || lmfc_cnt_reg >= k_eff - 9'h001) begin
      lmfc_cnt_reg <= 9'h000;
    end else begin
      lmfc_cnt_reg <= lmfc_cnt_reg + 9'h001;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      LMFC_PULSE <= 1'b0;
    end else begin
      LMFC_PULSE <= link_on && lmfc_cnt_reg == 9'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // combined active-low sync request

  slc_sync_select u_sync (
    .clk         (CORE_CLK),
    .rst_n       (RST_N),
    .sync_pin_n  (LINK.sync_pin_n),
    .tmstp_pin_n (LINK.tmstp_pin_n),
    .sel         (link_control_reg[`SLC_SYNC_SEL_HI:`SLC_SYNC_SEL_LO]),
    .soft_n      (soft_sync_reg[0]),
    .req_n       (SYNC_REQ_N)
  );
endmodule

// File: verilog/slc_map.svh
/*
  Constants for the serial link control registers: offsets, reset values,
  field positions and host-side command map.
  Assumes it is included by bare name by the package users.
*/
`ifndef SLC_MAP_SVH
`define SLC_MAP_SVH

// device register offsets (12-bit register port)
`define SLC_OFS_CAL_ENABLE   12'h061
`define SLC_OFS_MODE_LOCK    12'h062
`define SLC_OFS_LINK_ENABLE  12'h200
`define SLC_OFS_LINK_MODE    12'h201
`define SLC_OFS_KM1          12'h202
`define SLC_OFS_SOFT_SYNC    12'h203
`define SLC_OFS_LINK_CONTROL 12'h204

// device reset values
`define SLC_RST_CAL_ENABLE   8'h01
`define SLC_RST_MODE_LOCK    8'hff
`define SLC_RST_LINK_ENABLE  8'h01
`define SLC_RST_LINK_MODE    8'h02
`define SLC_RST_KM1          8'h1f
`define SLC_RST_SOFT_SYNC    8'h01
`define SLC_RST_LINK_CONTROL 8'h03

// field positions
`define SLC_BIT_ENABLE       0
`define SLC_SYNC_SEL_HI      3
`define SLC_SYNC_SEL_LO      2

// sync source codes
`define SLC_SYNC_SEL_PIN     2'h0
`define SLC_SYNC_SEL_TMSTP   2'h1
`define SLC_SYNC_SEL_NONE    2'h2

// link modes from this code upward use 64b/66b framing
`define SLC_MODE_6466_FIRST  8'h10
`define SLC_K_6466_FACTOR    10'h100
`define SLC_K_E_DEFAULT      10'h001

// legal range of K-1 enforced by the controller
`define SLC_KM1_MIN          8'h03
`define SLC_KM1_MAX          8'h1f

// controller APB offsets
`define SLC_APB_CMD_ADDR     12'h000
`define SLC_APB_CMD_DATA     12'h004
`define SLC_APB_CMD_GO       12'h008
`define SLC_APB_STATUS       12'h00c
`define SLC_GO_BIT_START     0
`define SLC_GO_BIT_WRITE     1

`endif

// File: verilog/slc_pkg.sv
/*
  Types shared by both ends of the serial link control block.
  Assumes slc_map.svh on the include path.
*/
package slc_pkg;
  typedef logic [7:0]  slc_byte_t;
  typedef logic [11:0] slc_addr_t;
  typedef logic [8:0]  slc_kcount_t;
  typedef enum logic [1:0] {
    SLC_H_IDLE = 2'b01,
    SLC_H_BUSY = 2'b10
  } slc_hstate_t;
endpackage

// File: verilog/slc_link_if.sv
/*
  Interface joining the controller end and the device end: a request/ack
  register port and the two active-low sync pins.
  Assumes both ends run on the same CORE_CLK.
*/
`timescale 1ns/100ps
interface slc_link_if;
  import slc_pkg::*;
  logic      reg_req;
  logic      reg_wr;
  slc_addr_t reg_addr;
  slc_byte_t reg_wdata;
  logic      reg_ack;
  slc_byte_t reg_rdata;
  logic      sync_pin_n;
  logic      tmstp_pin_n;

  modport dev (
    input  reg_req, reg_wr, reg_addr, reg_wdata, sync_pin_n, tmstp_pin_n,
    output reg_ack, reg_rdata
  );
  modport ctl (
    output reg_req, reg_wr, reg_addr, reg_wdata, sync_pin_n, tmstp_pin_n,
    input  reg_ack, reg_rdata
  );
endinterface

// File: verilog/slc_sync_select.sv
/*
  Sync request combiner: synchronises both sync pins, picks one by the
  source select and merges it with the software request.
  Assumes pins are asynchronous to clk; sel and soft_n come from clk logic.
*/
`timescale 1ns/100ps
`include "slc_map.svh"
module slc_sync_select
  import slc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sync_pin_n,
  input  wire logic       tmstp_pin_n,
  input  wire logic [1:0] sel,
  input  wire logic       soft_n,
  output logic            req_n
);
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic       pin_sel_n;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; meta stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta_reg <= 2'h3;
      pin_sync_reg <= 2'h3;
    end else begin
      pin_meta_reg <= {tmstp_pin_n, sync_pin_n};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source pick; codes 2 and 3 use no pin, so a stuck pin can be escaped
  always_comb begin
    case (sel)
      `SLC_SYNC_SEL_PIN:   pin_sel_n = pin_sync_reg[0];
      `SLC_SYNC_SEL_TMSTP: pin_sel_n = pin_sync_reg[1];
      default:             pin_sel_n = 1'b1;
    endcase
  end

  // software request always counts, whatever pin is chosen
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_n <= 1'b1;
    end else begin
      req_n <= pin_sel_n & soft_n;
    end
  end
endmodule

// File: verilog/slc_controller.sv
/*
  Controller end: an APB slave with command and status registers that
  drives the device register port, refuses writes that break the link
  configuration order, and drives the sync pins from the receiver.
  Assumes a single CORE_CLK and a device that acks every request.
*/
`timescale 1ns/100ps
`include "slc_map.svh"
module slc_controller
  import slc_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  input  wire logic        RX_SYNC_N,
  input  wire logic        RX_TMSTP_N,
  slc_link_if.ctl          LINK
);
  slc_hstate_t state_reg;
  slc_addr_t   cmd_addr_reg;
  slc_byte_t   cmd_data_reg;
  logic        cmd_wr_reg;
  slc_byte_t   rsp_data_reg;
  logic        refused_reg;
  logic        en_shadow_reg;
  logic        cal_shadow_reg;
  logic        req_reg;
  logic        go;
  logic        allowed;
  logic        setup;
  logic        access;

  function automatic logic is_cfg(input slc_addr_t a);
    return a == `SLC_OFS_LINK_MODE || a == `SLC_OFS_KM1
        || a == `SLC_OFS_LINK_CONTROL;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: answer in the first access cycle; reads are looked up at setup,
  // writes land only at the access edge that completes the transfer

  assign setup  = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE & PREADY;
  assign go     = access & PWRITE & PADDR == `SLC_APB_CMD_GO
               & PWDATA[`SLC_GO_BIT_START] & state_reg == SLC_H_IDLE;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & PADDR != `SLC_APB_CMD_ADDR & PADDR != `SLC_APB_CMD_DATA
               & PADDR != `SLC_APB_CMD_GO & PADDR != `SLC_APB_STATUS;
      if (setup && !PWRITE) begin
        case (PADDR)
          `SLC_APB_CMD_ADDR: PRDATA <= {20'h00000, cmd_addr_reg};
          `SLC_APB_CMD_DATA: PRDATA <= {24'h000000, cmd_data_reg};
          `SLC_APB_STATUS:   PRDATA <= {16'h0000, rsp_data_reg, 6'h00,
                                        refused_reg, state_reg == SLC_H_BUSY};
          default:           PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // command fields; ignored while a transfer is running
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cmd_addr_reg <= 12'h000;
      cmd_data_reg <= 8'h00;
      cmd_wr_reg   <= 1'b0;
    end else if (access && PWRITE && state_reg == SLC_H_IDLE) begin
      if (PADDR == `SLC_APB_CMD_ADDR) cmd_addr_reg <= PWDATA[11:0];
      if (PADDR == `SLC_APB_CMD_DATA) cmd_data_reg <= PWDATA[7:0];
      if (PADDR == `SLC_APB_CMD_GO)   cmd_wr_reg   <= PWDATA[`SLC_GO_BIT_WRITE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ordering guard on writes, judged from the shadows of enable and cal
  always_comb begin
    allowed = 1'b1;
    if (PWDATA[`SLC_GO_BIT_WRITE]) begin
      if (is_cfg(cmd_addr_reg) && en_shadow_reg) allowed = 1'b0;
      if (cmd_addr_reg == `SLC_OFS_LINK_MODE && cal_shadow_reg)
        allowed = 1'b0;
      if (cmd_addr_reg == `SLC_OFS_LINK_ENABLE && cmd_data_reg[0]
          && !cal_shadow_reg) allowed = 1'b0;
      if (cmd_addr_reg == `SLC_OFS_CAL_ENABLE && !cmd_data_reg[0]
          && en_shadow_reg) allowed = 1'b0;
      if (cmd_addr_reg == `SLC_OFS_KM1 && (cmd_data_reg < `SLC_KM1_MIN
          || cmd_data_reg > `SLC_KM1_MAX)) allowed = 1'b0;
    end
  end

  // sequencer: request held until the device acks
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_reg   <= SLC_H_IDLE;
      req_reg     <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      case (state_reg)
        SLC_H_IDLE: begin
          if (go) begin
            refused_reg <= ~allowed;
            if (allowed) begin
              state_reg <= SLC_H_BUSY;
              req_reg   <= 1'b1;
            end
          end
        end
        SLC_H_BUSY: begin
          if (LINK.reg_ack) begin
            state_reg <= SLC_H_IDLE;
            req_reg   <= 1'b0;
          end
        end
        default: begin
          state_reg <= SLC_H_IDLE;
          req_reg   <= 1'b0;
        end
      endcase
    end
  end

  // shadows track what the device now holds, plus read answer capture
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      en_shadow_reg  <= 1'(`SLC_RST_LINK_ENABLE);
      cal_shadow_reg <= 1'(`SLC_RST_CAL_ENABLE);
      rsp_data_reg   <= 8'h00;
    end else if (state_reg == SLC_H_BUSY && LINK.reg_ack) begin
      if (!cmd_wr_reg) rsp_data_reg <= LINK.reg_rdata;
      if (cmd_wr_reg && cmd_addr_reg == `SLC_OFS_LINK_ENABLE)
        en_shadow_reg <= cmd_data_reg[0];
      if (cmd_wr_reg && cmd_addr_reg == `SLC_OFS_CAL_ENABLE)
        cal_shadow_reg <= cmd_data_reg[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side drive; sync pins are registered copies of receiver requests
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      LINK.sync_pin_n  <= 1'b1;
      LINK.tmstp_pin_n <= 1'b1;
    end else begin
      LINK.sync_pin_n  <= RX_SYNC_N;
      LINK.tmstp_pin_n <= RX_TMSTP_N;
    end
  end

  assign LINK.reg_req   = req_reg;
  assign LINK.reg_wr    = cmd_wr_reg;
  assign LINK.reg_addr  = cmd_addr_reg;
  assign LINK.reg_wdata = cmd_data_reg;
endmodule

// File: bench/slc_link_checker_sva.sv
/*
  Checker for the link register port and the device outputs that follow it.
  Assumes one CORE_CLK; the bench instantiates it beside slc_link_if.
*/
`timescale 1ns/100ps
`include "slc_map.svh"
module slc_link_checker
  import slc_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic        reg_req,
  input wire logic        reg_wr,
  input wire slc_addr_t   reg_addr,
  input wire slc_byte_t   reg_wdata,
  input wire logic        reg_ack,
  input wire logic        LINK_RESET_N,
  input wire logic        SERDES_PWRDN,
  input wire logic        LINK_CLK_EN,
  input wire logic        LMFC_PULSE,
  input wire logic        SYNC_REQ_N,
  input wire slc_byte_t   LINK_MODE,
  input wire slc_kcount_t K_EFFECTIVE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////
  // an acked write to one offset, with an extra condition on the data or the link mode
  sequence s_wr_ack(logic [11:0] ofs, logic cond);
    reg_ack && reg_wr && reg_addr == ofs && cond;
  endsequence
  property p_ack_pulse;
    reg_ack |=> !reg_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_after_req;
    reg_req && !reg_ack |=> reg_ack;
  endproperty
  a_ack_after_req: assert property (p_ack_after_req) else $error("request not acked");
  // reset, power-down and clock gate must never disagree
  property p_off_together;
    LINK_RESET_N == LINK_CLK_EN && SERDES_PWRDN == !LINK_CLK_EN;
  endproperty
  a_off_together: assert property (p_off_together) else $error("gating mismatch");
  // one cycle of slack: the pulse flop switches on the same edge as the gate
  property p_lmfc_off;
    !LINK_CLK_EN && !$past(LINK_CLK_EN) |-> !LMFC_PULSE;
  endproperty
  a_lmfc_off: assert property (p_lmfc_off) else $error("frame pulse while off");
  // the counter was held at zero, so the first enabled cycle carries a pulse
  property p_lmfc_restart;
    LINK_CLK_EN && !$past(LINK_CLK_EN) |-> LMFC_PULSE;
  endproperty
  a_lmfc_restart: assert property (p_lmfc_restart) else $error("counter not restarted");
  property p_enable_write;
    s_wr_ack(`SLC_OFS_LINK_ENABLE, 1'h1) |=> LINK_CLK_EN == $past(reg_wdata[0]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not applied");
  property p_soft_sync;
    s_wr_ack(`SLC_OFS_SOFT_SYNC, !reg_wdata[0]) |=> !SYNC_REQ_N;
  endproperty
  a_soft_sync: assert property (p_soft_sync) else $error("soft request ignored");
  property p_km1_write;
    s_wr_ack(`SLC_OFS_KM1, LINK_MODE < `SLC_MODE_6466_FIRST)
      |=> K_EFFECTIVE == 9'($past(reg_wdata)) + 9'h001;
  endproperty
  a_km1_write: assert property (p_km1_write) else $error("frame count wrong");
  property p_mode_write;
    s_wr_ack(`SLC_OFS_LINK_MODE, reg_wdata >= `SLC_MODE_6466_FIRST)
      |=> LINK_MODE == $past(reg_wdata) && K_EFFECTIVE == (9'h100 >> $past(reg_wdata[1:0]));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("derived count wrong");
endmodule

// File: bench/test_serial_link_control_regs.sv
/*
  Bench: drives the controller over APB and the receiver sync lines; the two
  ends meet in slc_link_if. Assumes the hand-over timing of both ends.
*/
`timescale 1ns/100ps
`include "slc_map.svh"
module test_serial_link_control_regs;
  import slc_pkg::*;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        psel = 1'h0;
  logic        pen = 1'h0;
  logic        pwr = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        sysref = 1'h0;
  logic        rx_sync_n = 1'h1;
  logic        rx_tmstp_n = 1'h1;
  logic        pready, pslverr, err, lrst_n, pwrdn, clk_en, lmfc, sync_n, scr, sgn;
  logic [31:0] prdata, rd;
  slc_byte_t   mode;
  slc_kcount_t k_eff;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  slc_link_if link_if ();
  slc_controller slc_controller_inst (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .RX_SYNC_N(rx_sync_n), .RX_TMSTP_N(rx_tmstp_n),
    .LINK(link_if));
  slc_device slc_device_inst (.CORE_CLK(clk), .RST_N(rst_n), .LINK(link_if), .SYSREF(sysref),
    .LINK_RESET_N(lrst_n), .SERDES_PWRDN(pwrdn), .LINK_CLK_EN(clk_en), .LMFC_PULSE(lmfc),
    .SYNC_REQ_N(sync_n), .LINK_MODE(mode), .K_EFFECTIVE(k_eff), .SCRAMBLE_EN(scr),
    .SAMPLE_SIGNED(sgn));
  slc_link_checker slc_link_checker_inst (.CORE_CLK(clk), .RST_N(rst_n),
    .reg_req(link_if.reg_req), .reg_wr(link_if.reg_wr), .reg_addr(link_if.reg_addr),
    .reg_wdata(link_if.reg_wdata), .reg_ack(link_if.reg_ack), .LINK_RESET_N(lrst_n),
    .SERDES_PWRDN(pwrdn), .LINK_CLK_EN(clk_en), .LMFC_PULSE(lmfc), .SYNC_REQ_N(sync_n),
    .LINK_MODE(mode), .K_EFFECTIVE(k_eff));
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one APB transfer; an idle cycle after it keeps strobes from re-rising in one step
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask
  // device register access through the command registers; rd ends as status
  task dev(input logic wr, input logic [11:0] ofs, input logic [7:0] v);
    apb(1'h1, `SLC_APB_CMD_ADDR, {20'h00000, ofs});
    apb(1'h1, `SLC_APB_CMD_DATA, {24'h000000, v});
    apb(1'h1, `SLC_APB_CMD_GO, {30'h0, wr, 1'h1});
    do begin
      apb(1'h0, `SLC_APB_STATUS, 32'h0);
    end while (rd[0] !== 1'h0);
  endtask
  task wait_cycles(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [11:0] ofs [5] = '{12'h200, 12'h201, 12'h202, 12'h203, 12'h204};
    logic [7:0]  rv [5] = '{8'h01, 8'h02, 8'h1f, 8'h01, 8'h03};
    for (int i = 0; i < 5; i++) begin
      dev(1'h0, ofs[i], 8'h00);
      check(rd[15:8], rv[i]);
    end
    check({lrst_n, pwrdn, clk_en, sync_n}, 4'hb);
    check(k_eff, 9'h020);
    check(mode, 8'h02);
    check({scr, sgn}, 2'h3);
    apb(1'h0, 12'h010, 32'h0);
    check(err, 1'h1);
    $display("reset values done");
  endtask
  task t_disable;
    int seen;
    seen = 0;
    dev(1'h1, `SLC_OFS_KM1, 8'h0f);
    check({rd[1], k_eff}, {1'h1, 9'h020});
    dev(1'h1, `SLC_OFS_LINK_ENABLE, 8'h00);
    check({lrst_n, pwrdn, clk_en}, 3'h2);
    // an alignment event while off must not start the frame counter
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      sysref <= (i < 20);
      seen += (lmfc === 1'h1);
    end
    check(seen, 0);
    dev(1'h1, `SLC_OFS_KM1, 8'h07);
    check(k_eff, 9'h008);
    dev(1'h1, `SLC_OFS_KM1, 8'h20);
    check(rd[1], 1'h1);
    dev(1'h1, `SLC_OFS_LINK_MODE, 8'h10);
    check(rd[1], 1'h1);
    $display("disable done");
  endtask
  task t_mode;
    int seen;
    seen = 0;
    dev(1'h1, `SLC_OFS_CAL_ENABLE, 8'h00);
    for (int i = 0; i < 4; i++) begin
      dev(1'h1, `SLC_OFS_LINK_MODE, 8'(8'h10 + i));
      check({mode, k_eff}, {8'(8'h10 + i), 9'(9'h100 >> i)});
    end
    dev(1'h1, `SLC_OFS_LINK_MODE, 8'h02);
    check(k_eff, 9'h008);
    dev(1'h1, `SLC_OFS_LINK_ENABLE, 8'h01);
    check({rd[1], clk_en}, 2'h2);
    dev(1'h1, `SLC_OFS_CAL_ENABLE, 8'h01);
    dev(1'h1, `SLC_OFS_LINK_ENABLE, 8'h01);
    check(clk_en, 1'h1);
    // a period of eight frames gives exactly eight pulses in 64 cycles
    repeat (64) begin
      @(posedge clk);
      seen += (lmfc === 1'h1);
    end
    check(seen, 8);
    dev(1'h1, `SLC_OFS_CAL_ENABLE, 8'h00);
    check(rd[1], 1'h1);
    $display("mode done");
  endtask
  task t_sync;
    dev(1'h1, `SLC_OFS_LINK_ENABLE, 8'h00);
    rx_sync_n <= 1'h0;
    wait_cycles(5);
    check(sync_n, 1'h0);
    dev(1'h1, `SLC_OFS_LINK_CONTROL, 8'h08);
    check({scr, sgn, sync_n}, 3'h1);
    dev(1'h1, `SLC_OFS_LINK_CONTROL, 8'h0b);
    check(sync_n, 1'h1);
    dev(1'h1, `SLC_OFS_LINK_CONTROL, 8'h07);
    rx_tmstp_n <= 1'h0;
    wait_cycles(5);
    check(sync_n, 1'h0);
    rx_tmstp_n <= 1'h1;
    rx_sync_n <= 1'h1;
    wait_cycles(5);
    check(sync_n, 1'h1);
    for (int s = 0; s < 3; s++) begin
      dev(1'h1, `SLC_OFS_LINK_CONTROL, 8'(4 * s + 3));
      dev(1'h1, `SLC_OFS_SOFT_SYNC, 8'h00);
      check(sync_n, 1'h0);
      dev(1'h1, `SLC_OFS_SOFT_SYNC, 8'h01);
      check(sync_n, 1'h1);
    end
    $display("sync done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog: the full run needs well under 3000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_reset();
    t_disable();
    t_mode();
    t_sync();
    stop_test();
  end
endmodule
